/* pdl_station.sv */
`timescale 1ns/10ps
// How it works
// - Master polls one slave per communication cycle; a full sweep polls every recognised slave, or every slave during recognition.
// - A polled slave replies with its link data registers.
// - Master stores each reply into that slave's own data block.
// - Link traffic runs on its own, waiting for the program scan only to refresh a received reply.
// - Received data reaches the data registers only at end of scan.
// - Per-slave completion flag is high for exactly one scan after refresh.
// - Master raises the all-slaves flag for one scan; slaves never do.
// - Register station numbers outside 1 to 31 fall back to the configured constant.
// - Register-sourced numbering takes the station number from the per-port register.
// - A link-initialize pulse restarts the link and re-recognizes the slaves.
// - Master sends its transmit word count and accepts its receive word count.
// - At 19200 bps slot is 4.2 ms plus 2.4 ms per word plus a scan.
// - At 38400 bps slot is 2.2 ms plus 1.3 ms per word plus a scan.
// - At 57600 bps slot is 1.6 ms plus 0.9 ms per word plus a scan.
// - Slave flags link stopped after 10 s without a request for its own station; clears on such a request.
module pdl_station
    import pdl_pkg::*;
#(
    parameter int WORD_W = 16,
    parameter int MAX_WORDS = 8,
    parameter int NUM_SLAVES = MAX_SLAVES,
    parameter int T19_OVH = T19_OVH_CYC,
    parameter int T19_WORD = T19_WORD_CYC,
    parameter int T38_OVH = T38_OVH_CYC,
    parameter int T38_WORD = T38_WORD_CYC,
    parameter int T57_OVH = T57_OVH_CYC,
    parameter int T57_WORD = T57_WORD_CYC,
    parameter int STOP_CYCLES = STOP_CYC,
    localparam int FW = MAX_WORDS * WORD_W,
    localparam int CNT_W = $clog2(MAX_WORDS + 1)
)(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic is_master,
    input wire logic [1:0] baud_sel,
    input wire logic [4:0] slave_count,
    input wire logic [CNT_W-1:0] tx_words,
    input wire logic [CNT_W-1:0] rx_words,
    input wire logic scan_end,
    input wire logic link_init_flag,
    input wire logic num_from_reg,
    input wire logic [15:0] port1_station_number_reg,
    input wire logic [4:0] station_const,
    input wire logic [FW-1:0] link_data_in,
    input wire logic [4:0] rd_slave,
    input wire logic link_rx_tgl,
    input wire logic [4:0] link_rx_addr,
    input wire logic link_rx_kind,
    input wire logic [FW-1:0] link_rx_data,
    output logic link_tx_tgl,
    output logic [4:0] link_tx_addr,
    output logic link_tx_kind,
    output logic [FW-1:0] link_tx_data,
    output logic link_tx_oe,
    output logic [NUM_SLAVES:1] slave_done_flag,
    output logic all_slaves_done_flag,
    output logic link_stopped_flag,
    output logic [FW-1:0] rd_data
);

    if (NUM_SLAVES < 1 || NUM_SLAVES > MAX_SLAVES || MAX_WORDS < 1 || WORD_W < 1)
    begin : g_bad_params
        $error("pdl_station: unsupported parameter values");
    end

    function automatic logic [FW-1:0] keep_words(input logic [FW-1:0] d, input logic [CNT_W-1:0] n);
        logic [FW-1:0] r;
        r = '0;
        for (int i = 0; i < MAX_WORDS; i++)
            if (i < int'(n))
                r[i*WORD_W +: WORD_W] = d[i*WORD_W +: WORD_W];
        return r;
    endfunction : keep_words

    // ======================================================================
    // Link input synchroniser
    // ======================================================================
    // The sender holds address, kind and data steady well before it flips
    // the toggle, so all fields are settled by the time the edge is seen.
    logic rx_tgl_s1_r, rx_tgl_s2_r, rx_tgl_s3_r;
    logic [4:0] rx_addr_s1_r, rx_addr_s2_r;
    logic rx_kind_s1_r, rx_kind_s2_r;
    logic [FW-1:0] rx_data_s1_r, rx_data_s2_r;

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            rx_tgl_s1_r <= 1'b0;
            rx_tgl_s2_r <= 1'b0;
            rx_tgl_s3_r <= 1'b0;
            rx_addr_s1_r <= '0;
            rx_addr_s2_r <= '0;
            rx_kind_s1_r <= 1'b0;
            rx_kind_s2_r <= 1'b0;
            rx_data_s1_r <= '0;
            rx_data_s2_r <= '0;
        end
        else
        begin
            rx_tgl_s1_r <= link_rx_tgl;
            rx_tgl_s2_r <= rx_tgl_s1_r;
            rx_tgl_s3_r <= rx_tgl_s2_r;
            rx_addr_s1_r <= link_rx_addr;
            rx_addr_s2_r <= rx_addr_s1_r;
            rx_kind_s1_r <= link_rx_kind;
            rx_kind_s2_r <= rx_kind_s1_r;
            rx_data_s1_r <= link_rx_data;
            rx_data_s2_r <= rx_data_s1_r;
        end
    end

    logic rx_frame;
    assign rx_frame = rx_tgl_s2_r ^ rx_tgl_s3_r;

    // ======================================================================
    // Station number selection
    // ======================================================================
    logic [4:0] own_stn;
    always_comb
    begin
        if (num_from_reg && port1_station_number_reg >= STN_REG_MIN && port1_station_number_reg <= STN_REG_MAX)
            own_stn = port1_station_number_reg[4:0];
        else
            own_stn = station_const;
    end

    a_stn_fallback: assert property (@(posedge core_clk) disable iff (rst)
        (num_from_reg && (port1_station_number_reg == 16'h0000 || port1_station_number_reg > STN_REG_MAX))
        |-> own_stn == station_const)
        else $error("Out-of-range register station number was not ignored.");

    // ======================================================================
    // Master polling sequencer
    // ======================================================================
    pdl_mst_e state_r;
    logic [4:0] poll_r;
    logic [31:0] slot_r;
    logic [NUM_SLAVES:1] known_r;
    logic init_sweep_r;
    logic got_rsp_r;
    logic sweep_ok_r;
    logic [FW-1:0] rsp_buf_r;
    logic [31:0] slot_cyc;
    logic [CNT_W:0] words_sum;
    logic mst_send;
    logic rsp_hit;
    logic last_poll;

    assign words_sum = {1'b0, tx_words} + {1'b0, rx_words};
    always_comb
    begin
        case (baud_sel)
            BAUD_19200: slot_cyc = 32'(T19_OVH) + 32'(T19_WORD) * 32'(words_sum);
            BAUD_38400: slot_cyc = 32'(T38_OVH) + 32'(T38_WORD) * 32'(words_sum);
            default: slot_cyc = 32'(T57_OVH) + 32'(T57_WORD) * 32'(words_sum);
        endcase
    end

    // Unrecognised slaves are polled only during a recognition sweep, which is
    // why a slave that powers up late stays unseen until the next reinitialize.
    assign mst_send = is_master && state_r == M_SEND && (init_sweep_r || known_r[poll_r]);
    assign rsp_hit = rx_frame && rx_kind_s2_r == KIND_RSP && rx_addr_s2_r == poll_r;
    assign last_poll = poll_r >= slave_count || poll_r >= 5'(NUM_SLAVES);

    // Polling never waits on scan_end except to hold a finished reply for refresh.
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            state_r <= M_IDLE;
            poll_r <= STN_FIRST;
            slot_r <= '0;
            known_r <= '0;
            init_sweep_r <= 1'b1;
            got_rsp_r <= 1'b0;
            sweep_ok_r <= 1'b1;
            rsp_buf_r <= '0;
        end
        else if (!is_master)
        begin
            state_r <= M_IDLE;
            poll_r <= STN_FIRST;
        end
        else if (link_init_flag)
        begin
            state_r <= M_SEND;
            poll_r <= STN_FIRST;
            known_r <= '0;
            init_sweep_r <= 1'b1;
            sweep_ok_r <= 1'b1;
        end
        else
        begin
            case (state_r)
                M_IDLE:
                begin
                    if (slave_count != 5'h00)
                        state_r <= M_SEND;
                end
                M_SEND:
                begin
                    got_rsp_r <= 1'b0;
                    slot_r <= slot_cyc;
                    if (mst_send)
                        state_r <= M_WAIT;
                    else
                    begin
                        sweep_ok_r <= 1'b0;
                        state_r <= M_NEXT;
                    end
                end
                M_WAIT:
                begin
                    if (rsp_hit && !got_rsp_r)
                    begin
                        got_rsp_r <= 1'b1;
                        rsp_buf_r <= keep_words(rx_data_s2_r, rx_words);
                        known_r[poll_r] <= 1'b1;
                    end
                    if (slot_r > 32'h0000_0001)
                        slot_r <= slot_r - 32'h0000_0001;
                    else if (got_rsp_r || rsp_hit)
                        state_r <= M_HOLD;
                    else
                    begin
                        sweep_ok_r <= 1'b0;
                        state_r <= M_NEXT;
                    end
                end
                M_HOLD:
                begin
                    if (scan_end)
                        state_r <= M_NEXT;
                end
                M_NEXT:
                begin
                    state_r <= M_SEND;
                    if (last_poll)
                    begin
                        poll_r <= STN_FIRST;
                        init_sweep_r <= 1'b0;
                        sweep_ok_r <= 1'b1;
                    end
                    else
                        poll_r <= poll_r + 5'h01;
                end
                default: state_r <= M_IDLE;
            endcase
        end
    end

    a_slot_time: assert property (@(posedge core_clk) disable iff (rst)
        (mst_send && !link_init_flag) |=> slot_r == $past(slot_cyc))
        else $error("Slot length does not match the baud-rate timing.");

    a_init_resweep: assert property (@(posedge core_clk) disable iff (rst)
        (is_master && link_init_flag) |=> (known_r == '0 && poll_r == STN_FIRST && init_sweep_r))
        else $error("Link initialize did not restart recognition.");

    // ======================================================================
    // Master data blocks, one per slave
    // ======================================================================
    logic [FW-1:0] store_r [1:NUM_SLAVES];
    logic mst_refresh;
    assign mst_refresh = is_master && state_r == M_HOLD && scan_end && !link_init_flag;

    for (genvar s = 1; s <= NUM_SLAVES; s++)
    begin : g_store
        always_ff @(posedge core_clk or posedge rst)
        begin
            if (rst)
                store_r[s] <= '0;
            else if (mst_refresh && poll_r == 5'(s))
                store_r[s] <= rsp_buf_r;
        end
    end

    a_store_block: assert property (@(posedge core_clk) disable iff (rst)
        mst_refresh |=> store_r[$past(poll_r)] == $past(rsp_buf_r))
        else $error("Reply was not stored in the polled slave's block.");

    // ======================================================================
    // Slave responder
    // ======================================================================
    logic slv_req;
    logic slv_reply;
    logic slv_pending_r;
    logic [FW-1:0] slv_buf_r;
    logic [FW-1:0] slv_data_r;
    logic [31:0] stop_cnt_r;

    assign slv_req = !is_master && rx_frame && rx_kind_s2_r == KIND_REQ;
    assign slv_reply = slv_req && rx_addr_s2_r == own_stn;

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            slv_pending_r <= 1'b0;
            slv_buf_r <= '0;
            slv_data_r <= '0;
        end
        else if (scan_end)
        begin
            slv_pending_r <= slv_reply;
            slv_buf_r <= slv_reply ? rx_data_s2_r : slv_buf_r;
            if (slv_pending_r)
                slv_data_r <= slv_buf_r;
        end
        else if (slv_reply)
        begin
            slv_pending_r <= 1'b1;
            slv_buf_r <= rx_data_s2_r;
        end
    end

    a_refresh_at_end: assert property (@(posedge core_clk) disable iff (rst)
        $changed(slv_data_r) |-> $past(scan_end))
        else $error("Slave data changed outside end of scan.");

    // The stop timer also runs from reset, so a slave never addressed after
    // initialisation reports a stopped link too.
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            stop_cnt_r <= '0;
            link_stopped_flag <= 1'b0;
        end
        else if (is_master)
        begin
            stop_cnt_r <= '0;
            link_stopped_flag <= 1'b0;
        end
        else if (slv_reply)
        begin
            stop_cnt_r <= '0;
            link_stopped_flag <= 1'b0;
        end
        else if (stop_cnt_r >= 32'(STOP_CYCLES - 1))
            link_stopped_flag <= 1'b1;
        else
            stop_cnt_r <= stop_cnt_r + 32'h0000_0001;
    end

    a_stop_flag: assert property (@(posedge core_clk) disable iff (rst)
        (!is_master && !slv_reply && stop_cnt_r >= 32'(STOP_CYCLES - 1)) |=> link_stopped_flag)
        else $error("Link-stopped flag missed after the silence limit.");

    // ======================================================================
    // Link transmitter, shared by both roles
    // ======================================================================
    logic [4:0] oe_cnt_r;
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            link_tx_tgl <= 1'b0;
            link_tx_addr <= '0;
            link_tx_kind <= KIND_REQ;
            link_tx_data <= '0;
            link_tx_oe <= 1'b0;
            oe_cnt_r <= '0;
        end
        else if ((mst_send && !link_init_flag) || slv_reply)
        begin
            link_tx_tgl <= ~link_tx_tgl;
            link_tx_addr <= is_master ? poll_r : own_stn;
            link_tx_kind <= is_master ? KIND_REQ : KIND_RSP;
            link_tx_data <= is_master ? keep_words(link_data_in, tx_words) : link_data_in;
            link_tx_oe <= 1'b1;
            oe_cnt_r <= 5'(FRAME_HOLD_CYC - 1);
        end
        else if (oe_cnt_r != 5'h00)
            oe_cnt_r <= oe_cnt_r - 5'h01;
        else
            link_tx_oe <= 1'b0;
    end

    a_one_poll: assert property (@(posedge core_clk) disable iff (rst)
        (mst_send && !link_init_flag) |=> (link_tx_addr == $past(poll_r) && link_tx_kind == KIND_REQ
        && link_tx_tgl != $past(link_tx_tgl)))
        else $error("Master request not sent to the polled slave.");

    a_slave_reply: assert property (@(posedge core_clk) disable iff (rst)
        slv_reply |=> (link_tx_kind == KIND_RSP && link_tx_data == $past(link_data_in) && link_tx_oe))
        else $error("Slave reply does not carry its link data.");

    a_silent_other: assert property (@(posedge core_clk) disable iff (rst)
        (slv_req && rx_addr_s2_r != own_stn) |=> link_tx_tgl == $past(link_tx_tgl))
        else $error("Slave answered a request for another station.");

    // ======================================================================
    // Completion flags and read port
    // ======================================================================
    // Flags are rewritten at every end of scan, so each lasts exactly one scan.
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            slave_done_flag <= '0;
            all_slaves_done_flag <= 1'b0;
            rd_data <= '0;
        end
        else
        begin
            if (scan_end)
            begin
                for (int s = 1; s <= NUM_SLAVES; s++)
                    slave_done_flag[s] <= mst_refresh ? (poll_r == 5'(s)) : (s == 1 && slv_pending_r);
                all_slaves_done_flag <= mst_refresh && last_poll && sweep_ok_r;
            end
            if (!is_master)
                rd_data <= slv_data_r;
            else if (rd_slave >= STN_FIRST && rd_slave <= 5'(NUM_SLAVES))
                rd_data <= store_r[rd_slave];
            else
                rd_data <= '0;
        end
    end

    a_done_one_scan: assert property (@(posedge core_clk) disable iff (rst)
        $changed(slave_done_flag) |-> $past(scan_end))
        else $error("Completion flag changed inside a scan.");

    a_all_master: assert property (@(posedge core_clk) disable iff (rst)
        $rose(all_slaves_done_flag) |-> ($past(is_master) && $past(scan_end) && $past(last_poll)))
        else $error("All-slaves flag raised without a finished master sweep.");

endmodule : pdl_station

/* pdl_pkg.sv */
// ==========================================================================
// Shared constants for the polled station data link
// ==========================================================================
package pdl_pkg;

    // Core clock period.
    localparam real CLK_PERIOD_NS = 10.0;

    // Per-slave refresh cost: fixed overhead plus a cost per word, by baud rate.
    localparam real T19_OVH_MS = 4.2;
    localparam real T19_WORD_MS = 2.4;
    localparam real T38_OVH_MS = 2.2;
    localparam real T38_WORD_MS = 1.3;
    localparam real T57_OVH_MS = 1.6;
    localparam real T57_WORD_MS = 0.9;
    localparam int T19_OVH_CYC = int'($ceil(T19_OVH_MS * 1.0E6 / CLK_PERIOD_NS));
    localparam int T19_WORD_CYC = int'($ceil(T19_WORD_MS * 1.0E6 / CLK_PERIOD_NS));
    localparam int T38_OVH_CYC = int'($ceil(T38_OVH_MS * 1.0E6 / CLK_PERIOD_NS));
    localparam int T38_WORD_CYC = int'($ceil(T38_WORD_MS * 1.0E6 / CLK_PERIOD_NS));
    localparam int T57_OVH_CYC = int'($ceil(T57_OVH_MS * 1.0E6 / CLK_PERIOD_NS));
    localparam int T57_WORD_CYC = int'($ceil(T57_WORD_MS * 1.0E6 / CLK_PERIOD_NS));

    // Time without a request for its own station after which a slave reports the link stopped.
    localparam real STOP_TIME_S = 10.0;
    localparam int STOP_CYC = int'($ceil(STOP_TIME_S * 1.0E9 / CLK_PERIOD_NS));

    // Cycles a station keeps its line driver on after launching a frame.
    localparam int FRAME_HOLD_CYC = 16;

    localparam logic [1:0] BAUD_19200 = 2'h0;
    localparam logic [1:0] BAUD_38400 = 2'h1;
    localparam logic [1:0] BAUD_57600 = 2'h2;

    localparam int MAX_SLAVES = 31;
    localparam logic [4:0] STN_FIRST = 5'h01;
    localparam logic [15:0] STN_REG_MIN = 16'h0001;
    localparam logic [15:0] STN_REG_MAX = 16'h001F;

    localparam logic KIND_REQ = 1'b0;
    localparam logic KIND_RSP = 1'b1;

    typedef enum logic [2:0] {
        M_IDLE = 3'h0,
        M_SEND = 3'h1,
        M_WAIT = 3'h3,
        M_HOLD = 3'h2,
        M_NEXT = 3'h6
    } pdl_mst_e;

endpackage : pdl_pkg

/* pdl_slave_model.sv */
`timescale 1ns/10ps
// ==========================================================================
// Slave stations on the shared line, seen from the master
// ==========================================================================
module pdl_slave_model
    import pdl_pkg::*;
#(
    parameter int DELAY = 5
)(
    input wire logic core_clk,
    input wire logic [4:0] answer_max,
    input wire logic req_tgl,
    input wire logic [4:0] req_addr,
    input wire logic req_kind,
    output logic rsp_tgl,
    output logic [4:0] rsp_addr,
    output logic rsp_kind,
    output logic [127:0] rsp_data
);
    logic seen;
    logic [4:0] a;

    // Stations exist from time zero, so they are up before the master leaves reset.
    initial
    begin
        rsp_tgl = 1'b0;
        rsp_addr = 5'h00;
        rsp_kind = KIND_RSP;
        rsp_data = '0;
        seen = 1'b0;
        forever
        begin
            @(posedge core_clk);
            if (req_tgl !== seen)
            begin
                seen = req_tgl;
                a = req_addr;
                // Absent stations stay silent, so the master must skip them.
                if (req_kind === KIND_REQ && a != 5'h00 && a <= answer_max)
                begin
                    repeat (DELAY) @(posedge core_clk);
                    #1;
                    rsp_addr = a;
                    rsp_kind = KIND_RSP;
                    for (int i = 0; i < 8; i++) rsp_data[i*16 +: 16] = {3'h0, a, 4'hC, 4'(i)};
                    // Fields settle three cycles before the toggle marks the frame.
                    repeat (3) @(posedge core_clk);
                    #1;
                    rsp_tgl = ~rsp_tgl;
                end
            end
        end
    end
endmodule : pdl_slave_model

/* test_pdl_station.sv */
`timescale 1ns/10ps
module test_pdl_station import pdl_pkg::*; ;
    localparam int OVH [4] = '{40, 30, 20, 20};
    localparam int WRD [4] = '{20, 15, 10, 10};
    logic core_clk = 0, rst = 1, scan_end = 0, scan_fast = 0, link_init_flag = 0, num_from_reg = 1;
    logic [1:0] baud_sel = 2'h2;
    logic [4:0] slave_count = 5'h03, answer_max = 5'h03, station_const = 5'h07, rd_slave = 5'h01;
    logic [3:0] tx_words = 4'h2, rx_words = 4'h3;
    logic [15:0] stn_reg = 16'h0005;
    logic [127:0] m_din, s_din, s_rx_data = '0, p_data, m_data, s_data, m_rd, s_rd;
    logic p_tgl, p_kind, m_tgl, m_kind, m_oe, m_all, m_stop, s_tgl, s_kind, s_oe, s_all, s_stop;
    logic s_rx_tgl = 0, s_rx_kind = 0;
    logic [4:0] p_addr, m_addr, s_addr, s_rx_addr = 5'h00;
    logic [31:1] m_done, s_done;
    int mismatches = 0, compares = 0, scan_cnt = 0, m_all_seen = 0, s_all_seen = 0, m_done_seen = 0, s_done_seen = 0;

    function automatic logic [127:0] pat(input logic [4:0] a, input int n);
        logic [127:0] v;
        v = '0;
        for (int i = 0; i < n; i++) v[i*16 +: 16] = {3'h0, a, 4'hC, 4'(i)};
        return v;
    endfunction : pat

    always #5 core_clk = ~core_clk;

    pdl_station #(.T19_OVH(40), .T19_WORD(20), .T38_OVH(30), .T38_WORD(15), .T57_OVH(20), .T57_WORD(10),
        .STOP_CYCLES(200)) u_pdl_station (.core_clk(core_clk), .rst(rst), .is_master(1'b1), .baud_sel(baud_sel),
        .slave_count(slave_count), .tx_words(tx_words), .rx_words(rx_words), .scan_end(scan_end),
        .link_init_flag(link_init_flag), .num_from_reg(num_from_reg), .port1_station_number_reg(stn_reg),
        .station_const(station_const), .link_data_in(m_din), .rd_slave(rd_slave), .link_rx_tgl(p_tgl),
        .link_rx_addr(p_addr), .link_rx_kind(p_kind), .link_rx_data(p_data), .link_tx_tgl(m_tgl),
        .link_tx_addr(m_addr), .link_tx_kind(m_kind), .link_tx_data(m_data), .link_tx_oe(m_oe),
        .slave_done_flag(m_done), .all_slaves_done_flag(m_all), .link_stopped_flag(m_stop), .rd_data(m_rd));
    pdl_station #(.T19_OVH(40), .T19_WORD(20), .T38_OVH(30), .T38_WORD(15), .T57_OVH(20), .T57_WORD(10),
        .STOP_CYCLES(200)) u_pdl_station_slv (.core_clk(core_clk), .rst(rst), .is_master(1'b0), .baud_sel(baud_sel),
        .slave_count(slave_count), .tx_words(tx_words), .rx_words(rx_words), .scan_end(scan_end),
        .link_init_flag(link_init_flag), .num_from_reg(num_from_reg), .port1_station_number_reg(stn_reg),
        .station_const(station_const), .link_data_in(s_din), .rd_slave(rd_slave), .link_rx_tgl(s_rx_tgl),
        .link_rx_addr(s_rx_addr), .link_rx_kind(s_rx_kind), .link_rx_data(s_rx_data), .link_tx_tgl(s_tgl),
        .link_tx_addr(s_addr), .link_tx_kind(s_kind), .link_tx_data(s_data), .link_tx_oe(s_oe),
        .slave_done_flag(s_done), .all_slaves_done_flag(s_all), .link_stopped_flag(s_stop), .rd_data(s_rd));
    pdl_slave_model u_pdl_slave_model (.core_clk(core_clk), .answer_max(answer_max), .req_tgl(m_tgl),
        .req_addr(m_addr), .req_kind(m_kind), .rsp_tgl(p_tgl), .rsp_addr(p_addr), .rsp_kind(p_kind),
        .rsp_data(p_data));

    // ==========================================================================
    // Scan pacing and flag monitors
    // ==========================================================================
    always @(negedge core_clk)
    begin
        scan_cnt <= (scan_cnt == 49) ? 0 : scan_cnt + 1;
        scan_end <= scan_fast || (scan_cnt == 49);
    end

    always @(posedge core_clk)
    begin
        m_all_seen <= m_all_seen + int'(m_all === 1'b1);
        s_all_seen <= s_all_seen + int'(s_all === 1'b1);
        m_done_seen <= m_done_seen + int'(m_done[2] === 1'b1);
        s_done_seen <= s_done_seen + int'(s_done[1] === 1'b1);
    end

    // ==========================================================================
    // Shared tasks
    // ==========================================================================
    task automatic check(input logic [159:0] seen, input logic [159:0] exp);
        compares++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic wait_launch(output logic [4:0] a, output int n);
        logic old;
        old = m_tgl;
        for (n = 0; n < 600 && m_tgl === old; n++) @(negedge core_clk);
        if (n >= 600) mismatches++;
        a = m_addr;
    endtask : wait_launch

    task automatic send_req(input logic [4:0] a, input logic [127:0] d);
        s_rx_addr = a;
        s_rx_kind = KIND_REQ;
        s_rx_data = d;
        repeat (3) @(negedge core_clk);
        s_rx_tgl = ~s_rx_tgl;
        repeat (6) @(negedge core_clk);
    endtask : send_req

    task automatic give_verdict();
        $display("compares=%0d mismatches=%0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : give_verdict

    initial
    begin
        repeat (60000) @(posedge core_clk);
        mismatches++;
        give_verdict();
    end

    // ==========================================================================
    // Test sequence
    // ==========================================================================
    initial
    begin
        logic [4:0] a;
        logic old;
        logic found;
        int n;
        m_din = pat(5'h1A, 8);
        s_din = pat(5'h15, 8);
        repeat (4) @(negedge core_clk);
        rst = 1'b0;
        for (int i = 0; i < 6; i++)
        begin
            wait_launch(a, n);
            check(a, 5'(i % 3 + 1));
            check({m_kind, m_oe, m_stop, m_data}, {KIND_REQ, 1'b1, 1'b0, pat(5'h1A, 2)});
        end
        rd_slave = 5'h02;
        repeat (2) @(negedge core_clk);
        check(m_rd, pat(5'h02, 3));
        check(m_all_seen != 0 && m_done_seen != 0, 1'b1);
        $display("test polling finished");
        // A station that was silent during recognition stays skipped until the link restarts.
        slave_count = 5'h04;
        wait_launch(a, n);
        for (int i = 0; i < 4; i++)
        begin
            wait_launch(a, n);
            check(a == 5'h04, 1'b0);
        end
        answer_max = 5'h04;
        link_init_flag = 1'b1;
        @(negedge core_clk);
        link_init_flag = 1'b0;
        found = 1'b0;
        for (int i = 0; i < 6; i++)
        begin
            wait_launch(a, n);
            found = found | (a == 5'h04);
        end
        check(found, 1'b1);
        $display("test link restart finished");
        // With a one-cycle scan the launch spacing is the slot length plus three cycles.
        slave_count = 5'h01;
        scan_fast = 1'b1;
        for (int b = 0; b < 4; b++)
        begin
            baud_sel = 2'(b);
            tx_words = 4'(b + 1);
            rx_words = 4'(b);
            m_din = pat(5'(b), 8);
            wait_launch(a, n);
            wait_launch(a, n);
            wait_launch(a, n);
            check(n - OVH[b] - WRD[b] * (2 * b + 1) inside {[0:8]}, 1'b1);
            check(m_data, pat(5'(b), b + 1));
        end
        scan_fast = 1'b0;
        $display("test slot timing finished");
        check(s_stop, 1'b1);
        @(posedge scan_end);
        @(negedge core_clk);
        old = s_tgl;
        send_req(5'h07, pat(5'h09, 8));
        check(s_tgl, old);
        send_req(5'h05, pat(5'h09, 8));
        check({s_tgl, s_addr, s_kind, s_oe, s_data}, {~old, 5'h05, KIND_RSP, 1'b1, s_din});
        check({s_rd, s_stop}, {128'h0, 1'b0});
        repeat (120) @(negedge core_clk);
        check({s_oe, s_rd}, {1'b0, pat(5'h09, 8)});
        check(s_done_seen != 0 && s_all_seen == 0, 1'b1);
        for (int i = 0; i < 4; i++)
        begin
            num_from_reg = (i != 3);
            station_const = (i == 3) ? 5'h0A : 5'h07;
            s_din = pat(5'(i), 8);
            stn_reg = (i == 0) ? 16'h001F : (i == 1) ? 16'h0020 : (i == 2) ? 16'h0000 : 16'h0005;
            repeat (2) @(negedge core_clk);
            send_req((i == 0) ? 5'h1F : station_const, pat(5'h0B, 8));
            check({s_addr, s_kind, s_data}, {((i == 0) ? 5'h1F : station_const), KIND_RSP, pat(5'(i), 8)});
        end
        $display("test slave station finished");
        give_verdict();
    end
endmodule : test_pdl_station
